// File: verilog/irq_ctrl.sv
// Two-level interrupt controller: arbitration, dispatch timing, register file.
// Assumes the CPU core signals finished instructions, return instructions
// and protection key writes as one-cycle pulses on clk_i, and sleep state as a level.
//
// Summary of operation
// R01: A request during sleep adds five cycles plus the sleep mode wake-up time.
// R02: A return from a handler takes four or five cycles by program counter size.
// R03: All sources except the non-maskable lines are normal level; one vector chosen by software becomes high level.
// R04: High level preempts a running normal handler, which resumes afterwards.
// R05: Non-maskable requests ignore and never change the global interrupt enable.
// R06: No request of any level is taken while a non-maskable handler runs.
// R07: Simultaneous non-maskable requests are taken lowest vector first.
// R08: Without round-robin, the lowest pending normal vector wins.
// R09: With round-robin, the last taken normal vector ranks lowest next time.
// R10: Compact table sends NMI to 1, high to 2, all normal to 3.
// R11: Protected bits change only within four instructions after the key write.
// R12: Placement and compact bits need the key; round-robin bit does not.
// R13: Placement bit picks application start (from fuse) or boot section start.
// R14: Compact table bit enables the compact table, reset value zero.
// R15: NMI executing flag is read-only, set in handler, cleared on its return.
// R16: High executing flag stays set while preempted by NMI, clears on return.
// R17: Normal executing flag stays set while preempted, clears on its return.
// R18: Register at offset 2 records the last taken normal vector under round-robin.
// R19: After reset, normal arbitration starts with lowest vector highest.
// R20: High vector select is an eight-bit read-write register at 3, reset zero.
// R21: High vector select of zero disables the high level.
// R22: At least one instruction completes; minimum response is three cycles.
// R23: Writes to the executing flags are ignored.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps

module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [ADDR_W-1:0]    avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic [NUM_LINES-1:0] irq_line_i,
    input  wire logic                 global_enable_i,
    input  wire logic                 instr_done_i,
    input  wire logic                 return_from_interrupt_i,
    input  wire logic                 sleeping_i,
    input  wire logic [7:0]           wakeup_cycles_i,
    input  wire logic                 io_register_key_i,
    input  wire logic [7:0]           boot_section_end_fuse_i,
    output logic                      jump_valid_o,
    output jump_t                     jump_o,
    output logic                      return_done_o
);

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [IDX_W-1:0] first_set(input logic [NUM_LINES-1:0] m);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = IDX_W'(i);
            end
        end
        return idx;
    endfunction

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAKE,
        ST_FINISH,
        ST_PUSH,
        ST_RETURN
    } state_t;

    localparam logic [CNT_W-1:0] PUSH_LOAD   = CNT_W'(PUSH_CYC - 1);
    localparam logic [CNT_W-1:0] RETURN_LOAD = CNT_W'(RETURN_CYC - 1);
    // Waking replaces the finishing cycle, so it runs one count past the five extra cycles
    localparam logic [CNT_W-1:0] SLEEP_LOAD  = CNT_W'(SLEEP_EXTRA_CYC);
    localparam logic [2:0]       CCP_LOAD    = 3'(CCP_WINDOW_INSTR);

    state_t           state_r;
    logic [CNT_W-1:0] cnt_r;
    logic             rr_en_r;
    logic             compact_r;
    logic             place_boot_r;
    logic             nmi_ex_r;
    logic             high_ex_r;
    logic             normal_ex_r;
    logic [7:0]       last_vec_r;
    logic [7:0]       high_vec_r;
    logic [2:0]       ccp_cnt_r;
    level_t           sel_level_r;
    logic [IDX_W-1:0] sel_idx_r;
    logic             wait_r;
    logic [31:0]      rdata_r;
    logic             jump_valid_r;
    jump_t            jump_r;
    logic             ret_done_r;

    // ========================================================================
    // Arbitration
    // ========================================================================
    wire logic [7:0]           high_idx_w   = high_vec_r - 8'h01;
    wire logic                 high_on_w    = (high_vec_r != NO_HIGH_VECTOR) &&       // [R21]
                                              (high_vec_r <= 8'(NUM_LINES));
    wire logic [NUM_LINES-1:0] high_hot_w   = high_on_w ? (NUM_LINES'(1) << high_idx_w[IDX_W-1:0])
                                                        : '0;                         // [R03]
    wire logic [NUM_LINES-1:0] nmi_pend_w   = irq_line_i & NMI_LINE_MASK;
    wire logic [NUM_LINES-1:0] high_pend_w  = irq_line_i & high_hot_w & ~NMI_LINE_MASK;
    wire logic [NUM_LINES-1:0] norm_pend_w  = irq_line_i & ~high_hot_w & ~NMI_LINE_MASK;
    logic      [NUM_LINES-1:0] above_last_w;
    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            above_last_w[i] = (9'(i) + 9'h001) > {1'b0, last_vec_r};
        end
    end
    wire logic [NUM_LINES-1:0] rr_pend_w    = norm_pend_w & above_last_w;
    wire logic [NUM_LINES-1:0] norm_pick_w  = (rr_en_r && (|rr_pend_w)) ? rr_pend_w       // [R09]
                                                                        : norm_pend_w;    // [R08]
    // Non-maskable ignores the global enable and any other running level
    wire logic                 nmi_go_w     = (|nmi_pend_w) && !nmi_ex_r;                 // [R05] [R06]
    wire logic                 high_go_w    = (|high_pend_w) && global_enable_i &&
                                              !nmi_ex_r && !high_ex_r;                    // [R04] [R06]
    wire logic                 norm_go_w    = (|norm_pend_w) && global_enable_i &&
                                              !nmi_ex_r && !high_ex_r && !normal_ex_r;
    wire logic                 start_w      = nmi_go_w || high_go_w || norm_go_w;
    wire level_t               pick_level_w = nmi_go_w  ? LEV_NMI  :
                                              high_go_w ? LEV_HIGH : LEV_NORMAL;
    wire logic [IDX_W-1:0]     pick_idx_w   = nmi_go_w  ? first_set(nmi_pend_w) :         // [R07]
                                              high_go_w ? high_idx_w[IDX_W-1:0] :
                                                          first_set(norm_pick_w);

    // ========================================================================
    // Vector table
    // ========================================================================
    wire logic [7:0]  full_vec_w    = 8'(sel_idx_r) + 8'h01;
    wire logic [7:0]  compact_vec_w = (sel_level_r == LEV_NMI)  ? COMPACT_NMI_VEC :
                                      (sel_level_r == LEV_HIGH) ? COMPACT_HI_VEC  : COMPACT_NRM_VEC;
    wire logic [7:0]  table_vec_w   = compact_r ? compact_vec_w : full_vec_w;           // [R10] [R14]
    wire logic [15:0] app_base_w    = {8'h00, boot_section_end_fuse_i} * BOOT_BLOCK_WORDS;
    wire logic [15:0] table_base_w  = place_boot_r ? 16'h0000 : app_base_w;             // [R13]
    wire logic [15:0] vec_addr_w    = table_base_w + ({8'h00, table_vec_w} * VECTOR_STRIDE);

    // ========================================================================
    // Dispatch and return sequencer
    // ========================================================================
    wire logic  ret_go_w     = (state_r == ST_IDLE) && return_from_interrupt_i;
    wire logic  disp_go_w    = (state_r == ST_IDLE) && !return_from_interrupt_i && start_w;
    wire logic  cnt_zero_w   = (cnt_r == '0);
    wire logic  jump_fire_w  = (state_r == ST_PUSH) && cnt_zero_w;
    wire logic  ret_fire_w   = (state_r == ST_RETURN) && cnt_zero_w;
    wire logic  wake_load_w  = sleeping_i;
    wire logic [CNT_W-1:0] wake_cnt_w = SLEEP_LOAD + {1'b0, wakeup_cycles_i};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r     <= ST_IDLE;
            cnt_r       <= '0;
            sel_level_r <= LEV_NORMAL;
            sel_idx_r   <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (ret_go_w) begin
                        state_r <= ST_RETURN;
                        cnt_r   <= RETURN_LOAD;                                         // [R02]
                    end else if (disp_go_w) begin
                        sel_level_r <= pick_level_w;
                        sel_idx_r   <= pick_idx_w;
                        state_r     <= wake_load_w ? ST_WAKE : ST_FINISH;
                        cnt_r       <= wake_cnt_w;                                      // [R01]
                    end
                end
                ST_WAKE: begin
                    if (cnt_zero_w) begin
                        state_r <= ST_PUSH;
                        cnt_r   <= PUSH_LOAD;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_FINISH: begin
                    if (instr_done_i) begin                                             // [R22]
                        state_r <= ST_PUSH;
                        cnt_r   <= PUSH_LOAD;
                    end
                end
                ST_PUSH, ST_RETURN: begin
                    if (cnt_zero_w) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            jump_valid_r <= 1'b0;
            jump_r       <= '0;
            ret_done_r   <= 1'b0;
        end else begin
            jump_valid_r <= jump_fire_w;
            ret_done_r   <= ret_fire_w;
            if (jump_fire_w) begin
                jump_r <= '{level: sel_level_r, vector: table_vec_w, address: vec_addr_w};
            end
        end
    end

    // ========================================================================
    // Executing-level flags: a return clears the innermost running level
    // ========================================================================
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            nmi_ex_r    <= 1'b0;
            high_ex_r   <= 1'b0;
            normal_ex_r <= 1'b0;
        end else if (jump_fire_w) begin
            nmi_ex_r    <= nmi_ex_r    || (sel_level_r == LEV_NMI);                     // [R15]
            high_ex_r   <= high_ex_r   || (sel_level_r == LEV_HIGH);                    // [R16]
            normal_ex_r <= normal_ex_r || (sel_level_r == LEV_NORMAL);                  // [R17]
        end else if (ret_fire_w) begin
            if (nmi_ex_r) begin
                nmi_ex_r <= 1'b0;
            end else if (high_ex_r) begin
                high_ex_r <= 1'b0;
            end else begin
                normal_ex_r <= 1'b0;                                                    // [R04]
            end
        end
    end

    // ========================================================================
    // Configuration change protection window, counted in instructions
    // ========================================================================
    wire logic ccp_open_w = (ccp_cnt_r != 3'h0);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ccp_cnt_r <= 3'h0;
        end else if (io_register_key_i) begin
            ccp_cnt_r <= CCP_LOAD;                                                      // [R11]
        end else if (instr_done_i && ccp_open_w) begin
            ccp_cnt_r <= ccp_cnt_r - 3'h1;
        end
    end

    // ========================================================================
    // Avalon-MM slave: one wait cycle, then the access completes
    // ========================================================================
    wire logic [1:0] idx_w      = avs_address_i[ADDR_W-1:2];
    wire logic       req_w      = avs_read_i || avs_write_i;
    wire logic       wr_fire_w  = avs_write_i && !wait_r && avs_byteenable_i[0];
    wire logic [7:0] wdata_w    = avs_writedata_i[7:0];
    wire logic [7:0] ctrl_rd_w  = (8'(place_boot_r) << BIT_VECTOR_PLACEMENT) |
                                  (8'(compact_r) << BIT_COMPACT_TABLE) | (8'(rr_en_r) << BIT_ROUND_ROBIN);
    wire logic [7:0] flags_rd_w = (8'(nmi_ex_r) << BIT_NMI_EXEC) | (8'(high_ex_r) << BIT_HIGH_EXEC) |
                                  (8'(normal_ex_r) << BIT_NORMAL_EXEC);
    wire logic [7:0] rd_mux_w   = (idx_w == IDX_VECTOR_CONTROL)     ? ctrl_rd_w  :
                                  (idx_w == IDX_EXEC_FLAGS)         ? flags_rd_w :
                                  (idx_w == IDX_NORMAL_LAST_VECTOR) ? last_vec_r : high_vec_r;
    wire logic       rr_rec_w   = jump_fire_w && (sel_level_r == LEV_NORMAL) && rr_en_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= !(req_w && wait_r);
            if (avs_read_i && wait_r) begin
                rdata_r <= {24'h00_0000, rd_mux_w};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rr_en_r      <= REG_RESET[BIT_ROUND_ROBIN];                                 // [R19]
            compact_r    <= REG_RESET[BIT_COMPACT_TABLE];
            place_boot_r <= REG_RESET[BIT_VECTOR_PLACEMENT];
            last_vec_r   <= REG_RESET;
            high_vec_r   <= REG_RESET;
        end else begin
            if (wr_fire_w && idx_w == IDX_VECTOR_CONTROL) begin
                rr_en_r <= wdata_w[BIT_ROUND_ROBIN];                                    // [R12]
                if (ccp_open_w) begin
                    compact_r    <= wdata_w[BIT_COMPACT_TABLE];                         // [R12] [R14]
                    place_boot_r <= wdata_w[BIT_VECTOR_PLACEMENT];
                end
            end
            // Hardware record wins over a coincident software write
            if (rr_rec_w) begin
                last_vec_r <= full_vec_w;                                               // [R18]
            end else if (wr_fire_w && idx_w == IDX_NORMAL_LAST_VECTOR) begin
                last_vec_r <= wdata_w;
            end
            if (wr_fire_w && idx_w == IDX_HIGH_VECTOR_SELECT) begin
                high_vec_r <= wdata_w;                                                  // [R20]
            end
        end
    end

    assign avs_waitrequest_o = wait_r;
    assign avs_readdata_o    = rdata_r;
    assign jump_valid_o      = jump_valid_r;
    assign jump_o            = jump_r;
    assign return_done_o     = ret_done_r;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_quiet_three;
        !jump_valid_o [*3];
    endsequence

    sequence s_return_run;
        (state_r == ST_RETURN) [*4];
    endsequence

    a_min_response: assert property (disp_go_w |=> s_quiet_three)                        // [R22]
        else $error("vector issued sooner than three cycles after selection");
    a_return_length: assert property (ret_go_w |=> s_return_run ##1 return_done_o)      // [R02]
        else $error("return did not finish after its fixed cycle count");
    a_nmi_exclusive: assert property (disp_go_w |-> !nmi_ex_r)                           // [R06]
        else $error("request taken while a non-maskable handler runs");
    a_gie_gate: assert property (disp_go_w && pick_level_w != LEV_NMI |-> global_enable_i) // [R05]
        else $error("maskable request taken with interrupts disabled");
    a_high_disabled: assert property (high_vec_r == NO_HIGH_VECTOR && disp_go_w |-> pick_level_w != LEV_HIGH) // [R21]
        else $error("high level served while disabled");
    a_rr_record: assert property (jump_valid_o && jump_o.level == LEV_NORMAL && rr_en_r &&
                                  !compact_r |-> last_vec_r == jump_o.vector)            // [R18]
        else $error("last normal vector not recorded");
    a_ccp_guard: assert property (avs_write_i && !wait_r && !ccp_open_w |=>
                                  $stable(compact_r) && $stable(place_boot_r))           // [R11]
        else $error("protected bit changed outside the key window");
    a_flags_ro: assert property (!jump_fire_w && !ret_fire_w |=>
                                 $stable({nmi_ex_r, high_ex_r, normal_ex_r}))            // [R23]
        else $error("executing flags changed without dispatch or return");
    a_nmi_flag: assert property (jump_fire_w && sel_level_r == LEV_NMI |=> nmi_ex_r)     // [R15]
        else $error("non-maskable executing flag not set on dispatch");
    a_static_order: assert property (disp_go_w && pick_level_w == LEV_NORMAL && !rr_en_r |->
                                     pick_idx_w == first_set(norm_pend_w))               // [R08]
        else $error("static normal arbitration did not pick lowest vector");

endmodule

// File: verilog/irq_ctrl_pkg.sv
// Constants, register map and carrier types of the two-level interrupt controller.
// Assumes a single 40 MHz clock shared with the CPU core and the register bus.
package irq_ctrl_pkg;

    // ========================================================================
    // Register map (index = printed offset, byte address = 4 * index)
    // ========================================================================
    localparam logic [1:0] IDX_VECTOR_CONTROL     = 2'h0;
    localparam logic [1:0] IDX_EXEC_FLAGS         = 2'h1;
    localparam logic [1:0] IDX_NORMAL_LAST_VECTOR = 2'h2;
    localparam logic [1:0] IDX_HIGH_VECTOR_SELECT = 2'h3;
    localparam int         ADDR_W                 = 4;

    localparam int         BIT_ROUND_ROBIN        = 0;
    localparam int         BIT_COMPACT_TABLE      = 5;
    localparam int         BIT_VECTOR_PLACEMENT   = 6;
    localparam int         BIT_NORMAL_EXEC        = 0;
    localparam int         BIT_HIGH_EXEC          = 1;
    localparam int         BIT_NMI_EXEC           = 7;
    localparam logic [7:0] REG_RESET              = 8'h00;

    // ========================================================================
    // Sources and vector table
    // ========================================================================
    localparam int          NUM_LINES       = 32;
    localparam int          IDX_W           = 5;
    // Device dependent set of non-maskable lines, not software configurable
    localparam logic [31:0] NMI_LINE_MASK   = 32'h0000_0001;
    localparam logic [7:0]  NO_HIGH_VECTOR  = 8'h00;
    localparam logic [7:0]  COMPACT_NMI_VEC = 8'h01;
    localparam logic [7:0]  COMPACT_HI_VEC  = 8'h02;
    localparam logic [7:0]  COMPACT_NRM_VEC = 8'h03;
    localparam logic [15:0] VECTOR_STRIDE   = 16'h0002;
    localparam logic [15:0] BOOT_BLOCK_WORDS = 16'h0080;

    // ========================================================================
    // Timing, in CPU clock cycles
    // ========================================================================
    localparam int CLK_HZ           = 40_000_000;
    localparam int PUSH_CYC         = 2;
    localparam int SLEEP_EXTRA_CYC  = 5;
    localparam int RETURN_CYC_SHORT = 4;
    localparam int RETURN_CYC_LONG  = 5;
    localparam bit WIDE_PC          = 1'b0;
    localparam int RETURN_CYC       = WIDE_PC ? RETURN_CYC_LONG : RETURN_CYC_SHORT;
    localparam int CCP_WINDOW_INSTR = 4;
    localparam int CNT_W            = 9;

    typedef enum logic [1:0] {
        LEV_NMI,
        LEV_HIGH,
        LEV_NORMAL
    } level_t;

    typedef struct packed {
        level_t      level;
        logic [7:0]  vector;
        logic [15:0] address;
    } jump_t;

endpackage

// File: verif/cpu_model.sv
// CPU core stand-in that reports finished instructions to the controller.
// Assumes the controller samples instr_done_o on the rising edge of clk_i.
`timescale 1ns/100ps
module cpu_model (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic slow_i,
    output logic      instr_done_o
);
    // ==========
    // Pacing
    // ==========
    logic [1:0] cnt_r;
    // Slow mode stands for three-cycle instructions, so a request waits longer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= (cnt_r != 2'h0) ? cnt_r - 2'h1 : (slow_i ? 2'h2 : 2'h0);
        end
    end
    assign instr_done_o = rst_b_i && (cnt_r == 2'h0);
endmodule

// File: verif/tb_top.sv
// Self-checking bench of the interrupt controller: registers, protection, dispatch order.
// Assumes cpu_model paces instructions; the bench drives bus, lines and returns.
`timescale 1ns/100ps
module tb_top;
    import irq_ctrl_pkg::*;
    logic        clk_i, rst_b_i, rd, wr, gie, sleep, slow, wreq, jv, rdone, idone;
    logic [1:0]  pul;
    logic [3:0]  addr;
    logic [7:0]  wake, fuse;
    logic [31:0] wdata, rdata, irq, r;
    jump_t       jump;
    int          fails, n_checks, seed, i, rc, lat;
    bit          pl;
    logic [25:0] jq[$];
    logic [25:0] rq[$];
    irq_ctrl irq_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .irq_line_i(irq), .global_enable_i(gie), .instr_done_i(idone),
        .return_from_interrupt_i(pul[0]), .sleeping_i(sleep), .wakeup_cycles_i(wake),
        .io_register_key_i(pul[1]), .boot_section_end_fuse_i(fuse), .jump_valid_o(jv),
        .jump_o(jump), .return_done_o(rdone));
    cpu_model cpu_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow), .instr_done_o(idone));
    // ==========
    // Checking
    // ==========
    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_jump();
        chk(jump, (jq.size() > 0) ? jq.pop_front() : 26'h3ff_ffff);
    endtask
    task automatic cmp_read();
        chk({18'h0_0000, rdata[7:0]}, (rq.size() > 0) ? rq.pop_front() : 26'h3ff_ffff);
    endtask
    task automatic cmp_ret();
        chk(26'(rc), 26'(RETURN_CYC + 1));
    endtask
    always @(posedge clk_i) begin
        // Edges since the return pulse was seen
        rc = pul[0] ? 0 : rc + 1;
        if (jv) cmp_jump();
        if (!wreq && rd) cmp_read();
        if (rdone) cmp_ret();
    end
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ==========
    // Drivers
    // ==========
    task automatic wait_for(input int sel);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge clk_i);
            if (sel == 0 ? jv : (sel == 1 ? rdone : !wreq)) break;
        end
        lat = k;
        if (k == 300) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic bus(input bit w, input logic [1:0] idx, input logic [7:0] d);
        if (!w) rq.push_back({18'h0_0000, d});
        @(posedge clk_i);
        r = $random(seed);
        addr <= {idx, 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= {r[23:0], d};
        wait_for(2);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic pulse(input logic [1:0] v);
        @(posedge clk_i);
        pul <= v;
        @(posedge clk_i);
        pul <= 2'b00;
        if (v[0]) wait_for(1);
    endtask
    task automatic serve(input logic [31:0] lines, input level_t lev, input logic [7:0] vec, input bit ret);
        jq.push_back({lev, vec, (pl ? 16'h0000 : 16'(fuse) * BOOT_BLOCK_WORDS) + 16'(vec) * VECTOR_STRIDE});
        @(posedge clk_i);
        irq <= lines;
        wait_for(0);
        // Awake minimum seen here: three response cycles plus the registered output
        if (sleep) chk(26'(lat), 26'(4 + SLEEP_EXTRA_CYC + wake));
        else if (!slow) chk(26'(lat), 26'h000_0004);
        irq <= 32'h0000_0000;
        if (ret) pulse(2'b01);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        seed = 32'hccc0_8ba8;
        {rst_b_i, rd, wr, sleep, pul, addr, wdata, irq} = '0;
        {gie, slow} = 2'b11;
        wake = 8'h07 & 8'($random(seed));
        fuse = 8'($random(seed));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (i = 0; i < 4; i++) bus(1'b0, i[1:0], 8'h00);
        bus(1'b1, 2'h1, 8'hff);
        bus(1'b0, 2'h1, 8'h00);
        bus(1'b1, 2'h0, 8'h61);
        bus(1'b0, 2'h0, 8'h01);
        pulse(2'b10);
        bus(1'b1, 2'h0, 8'h60);
        pl = 1'b1;
        bus(1'b0, 2'h0, 8'h60);
        serve(32'h0000_0008, LEV_NORMAL, 8'h03, 1'b1);
        {gie, sleep} <= 2'b01;
        serve(32'h0000_0001, LEV_NMI, 8'h01, 1'b1);
        {gie, sleep} <= 2'b10;
        pulse(2'b10);
        bus(1'b1, 2'h0, 8'h00);
        pl = 1'b0;
        slow <= 1'b0;
        serve(32'h0000_0028, LEV_NORMAL, 8'h04, 1'b1);
        bus(1'b1, 2'h0, 8'h01);
        bus(1'b1, 2'h2, 8'h00);
        serve(32'h0000_0006, LEV_NORMAL, 8'h02, 1'b1);
        serve(32'h0000_0006, LEV_NORMAL, 8'h03, 1'b1);
        bus(1'b0, 2'h2, 8'h03);
        bus(1'b1, 2'h3, 8'h05);
        serve(32'h0000_0002, LEV_NORMAL, 8'h02, 1'b0);
        serve(32'h0000_0010, LEV_HIGH, 8'h05, 1'b0);
        bus(1'b0, 2'h1, 8'h03);
        serve(32'h0000_0011, LEV_NMI, 8'h01, 1'b0);
        bus(1'b0, 2'h1, 8'h83);
        for (i = 0; i < 3; i++) begin
            pulse(2'b01);
            bus(1'b0, 2'h1, (i == 0) ? 8'h03 : ((i == 1) ? 8'h01 : 8'h00));
        end
        bus(1'b1, 2'h3, 8'h00);
        serve(32'h0000_0010, LEV_NORMAL, 8'h05, 1'b1);
        complete_run();
    end
endmodule
